// *** pkg/serial_irq_pkg.sv ***
// shared constants for the fifo serial port request logic
package serial_irq_pkg;
  localparam int FIFO_DEPTH = 64;
  localparam int CNT_W      = 7;
  localparam int DATA_W     = 8;
  // fifo_count_reg field positions
  localparam int TX_CNT_LSB = 8;
  localparam int RX_CNT_LSB = 0;
  // request source positions in the flag vector
  localparam int SRC_TXLOW  = 0;
  localparam int SRC_TXSTOP = 1;
  localparam int SRC_RXFULL = 2;
  localparam int SRC_FAULT  = 3;
  localparam int SRC_BREAK  = 4;
  localparam int SRC_IDLE   = 5;
  localparam int NUM_SRC    = 6;
  localparam logic [NUM_SRC-1:0] FLAGS_RESET     = 6'h00;
  // sources still available in clock-synchronous mode
  localparam logic [NUM_SRC-1:0] SYNC_MODE_MASK  = 6'h05;
  // trigger counts selected by the two-bit level fields
  localparam logic [CNT_W-1:0] TX_TRIG_0 = 7'h08;
  localparam logic [CNT_W-1:0] TX_TRIG_1 = 7'h04;
  localparam logic [CNT_W-1:0] TX_TRIG_2 = 7'h02;
  localparam logic [CNT_W-1:0] TX_TRIG_3 = 7'h00;
  localparam logic [CNT_W-1:0] RX_TRIG_0 = 7'h01;
  localparam logic [CNT_W-1:0] RX_TRIG_1 = 7'h04;
  localparam logic [CNT_W-1:0] RX_TRIG_2 = 7'h08;
  localparam logic [CNT_W-1:0] RX_TRIG_3 = 7'h0E;
  localparam logic [CNT_W-1:0] FIFO_FULL_CNT = 7'h40;
  // receive sampling: base ticks per bit, latch on the fourth
  localparam logic [2:0] SAMPLE_TICK = 3'h3;
  localparam logic [3:0] DATA_BITS   = 4'h8;
  typedef enum {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP} rx_state_t;
endpackage

// *** pkg/byte_stream_if.sv ***
// byte stream with valid/ready between receiver, buffer and fifo
`timescale 1ns/100ps
interface byte_stream_if;
  logic       valid;
  logic       ready;
  logic [7:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// *** logic/two_entry_buffer.sv ***
// two-entry elastic buffer in the receive data path
`timescale 1ns/100ps
module two_entry_buffer
  import serial_irq_pkg::*;
(
  // clock and reset
  input wire logic   ref_clk,
  input wire logic   rst,
  // streams
  byte_stream_if.snk inStream,
  byte_stream_if.src outStream
);
  logic [DATA_W-1:0] entry0;
  logic [DATA_W-1:0] entry1;
  logic [1:0]        fill;
  logic              push;
  logic              pop;

  assign inStream.ready  = (fill != 2'h2);
  assign outStream.valid = (fill != 2'h0);
  assign outStream.data  = entry0;
  assign push = inStream.valid && inStream.ready;
  assign pop  = outStream.valid && outStream.ready;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      entry0 <= 8'h00;
      entry1 <= 8'h00;
      fill   <= 2'h0;
    end else begin
      if (push && pop) begin
        if (fill == 2'h1) begin
          entry0 <= inStream.data;
        end else begin
          entry0 <= entry1;
          entry1 <= inStream.data;
        end
      end else if (push) begin
        if (fill == 2'h0) begin
          entry0 <= inStream.data;
        end else begin
          entry1 <= inStream.data;
        end
        fill <= fill + 2'h1;
      end else if (pop) begin
        entry0 <= entry1;
        fill   <= fill - 2'h1;
      end
    end
  end

  occupancy_a : assert property (@(posedge ref_clk) disable iff (rst)
    fill != 2'h3) else $error("buffer fill out of range");
endmodule

// *** logic/fifo_serial_irq.sv ***
// fifo serial port: receiver, fifos, status flags, interrupt and dma requests
`timescale 1ns/100ps
// Functional notes
// - six asynchronous sources share three vectors in pairs.
// - clock-synchronous mode keeps only tx low and rx full sources.
// - each source has its own enable bit.
// - tx low request follows tx fifo low flag.
// - tx stop request follows tx stop flag.
// - rx full request follows rx fifo full flag.
// - fault, break and idle requests follow their flags.
// - dma only from tx low, tx stop and rx full.
// - dma-started tx stop flag clears on status read or full tx fifo.
// - a source never gives interrupt and dma request together.
// - tx low flag sets when tx count is at or below trigger.
// - tx low flag sets again if cleared while still at or below trigger.
// - tx count in bits 14 to 8, rx count in 6 to 0.
// - rx full flag sets when rx count reaches trigger.
// - rx full flag sets again if cleared while still at trigger.
// - break line all zero sets framing fault, maybe parity fault.
// - after a break no words enter rx fifo, receiver keeps running.
// - receiver syncs on start fall, latches on fourth base tick of eight.
module fifo_serial_irq
  import serial_irq_pkg::*;
(
  // clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rst,
  // mode and configuration
  input  wire logic              syncMode,
  input  wire logic [1:0]        txTriggerLevel,
  input  wire logic [1:0]        rxTriggerLevel,
  input  wire logic [7:0]        baseDivisor,
  input  wire logic              parityEnable,
  input  wire logic              parityOdd,
  // source enables
  input  wire logic              txFifoIrqEnable,
  input  wire logic              rxFullIrqEnable,
  input  wire logic              rxFaultIrqEnable,
  input  wire logic              lineBreakIrqEnable,
  input  wire logic              rxIdleIrqEnable,
  input  wire logic              txStopIrqEnable,
  // dma routing
  input  wire logic              dmaTxSelect,
  input  wire logic              dmaRxSelect,
  // software flag access
  input  wire logic [5:0]        flagClear,
  input  wire logic              statusRead,
  // external events
  input  wire logic              txStopEvent,
  input  wire logic              rxIdleEvent,
  // serial line
  input  wire logic              serialInputPin,
  // transmit fifo
  input  wire logic              txWriteStrobe,
  input  wire logic [7:0]        txWriteData,
  input  wire logic              txPopStrobe,
  output logic      [7:0]        txPopData,
  // receive fifo
  input  wire logic              rxReadStrobe,
  output logic      [7:0]        rxReadData,
  // status
  output logic      [14:0]       fifoCount,
  output logic                   txFifoLowFlag,
  output logic                   txStopFlag,
  output logic                   rxFifoFullFlag,
  output logic                   rxFaultFlag,
  output logic                   lineBreakFlag,
  output logic                   rxIdleReadyFlag,
  output logic                   framingFaultFlag,
  output logic                   parityFaultFlag,
  // requests
  output logic                   txLowRequest,
  output logic                   txStopRequest,
  output logic                   rxFullRequest,
  output logic                   rxFaultRequest,
  output logic                   breakRequest,
  output logic                   rxIdleRequest,
  output logic                   txVectorIrq,
  output logic                   faultVectorIrq,
  output logic                   rxVectorIrq,
  output logic                   dmaTxRequest,
  output logic                   dmaRxRequest
);
  logic [DATA_W-1:0] txMem [FIFO_DEPTH];
  logic [DATA_W-1:0] rxMem [FIFO_DEPTH];
  logic [5:0]        txWrPtr;
  logic [5:0]        txRdPtr;
  logic [5:0]        rxWrPtr;
  logic [5:0]        rxRdPtr;
  logic [CNT_W-1:0]  txCount;
  logic [CNT_W-1:0]  rxCount;
  logic [CNT_W-1:0]  txTrig;
  logic [CNT_W-1:0]  rxTrig;
  logic              txPush;
  logic              txPop;
  logic              rxPush;
  logic              rxPop;
  logic [NUM_SRC-1:0] flags;
  logic [NUM_SRC-1:0] flagSet;
  logic [NUM_SRC-1:0] enables;
  logic [NUM_SRC-1:0] active;
  logic [NUM_SRC-1:0] toDma;
  logic [NUM_SRC-1:0] irqOut;
  logic              stopDma;
  logic              stopAutoClear;
  rx_state_t         rxState;
  logic [7:0]        divCnt;
  logic              baseTick;
  logic [2:0]        tickCnt;
  logic              sampleStrobe;
  logic              prevPin;
  logic [3:0]        bitCnt;
  logic [7:0]        shiftData;
  logic              parityAcc;
  logic              wordDone;
  logic              wordGood;
  logic              frameFault;
  logic              parFault;
  logic              breakSeen;
  logic              overrun;
  logic              rxValid;
  logic [7:0]        rxWord;

  byte_stream_if rxStream ();
  byte_stream_if fifoStream ();

  two_entry_buffer rxBuffer (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .inStream  (rxStream),
    .outStream (fifoStream)
  );

  // trigger count lookup
  always_comb begin
    case (txTriggerLevel)
      2'h0:    txTrig = TX_TRIG_0;
      2'h1:    txTrig = TX_TRIG_1;
      2'h2:    txTrig = TX_TRIG_2;
      default: txTrig = TX_TRIG_3;
    endcase
    case (rxTriggerLevel)
      2'h0:    rxTrig = RX_TRIG_0;
      2'h1:    rxTrig = RX_TRIG_1;
      2'h2:    rxTrig = RX_TRIG_2;
      default: rxTrig = RX_TRIG_3;
    endcase
  end

  // transmit fifo, writes beyond full are dropped
  assign txPush = txWriteStrobe && (txCount != FIFO_FULL_CNT);
  assign txPop  = txPopStrobe && (txCount != 7'h00);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      txWrPtr   <= 6'h00;
      txRdPtr   <= 6'h00;
      txCount   <= 7'h00;
      txPopData <= 8'h00;
    end else begin
      if (txPush) begin
        txMem[txWrPtr] <= txWriteData;
        txWrPtr        <= txWrPtr + 6'h01;
      end
      if (txPop) begin
        txPopData <= txMem[txRdPtr];
        txRdPtr   <= txRdPtr + 6'h01;
      end
      txCount <= txCount + {6'h00, txPush} - {6'h00, txPop};
    end
  end

  // receive fifo; while a break is pending words are drained and discarded
  assign fifoStream.ready = (rxCount != FIFO_FULL_CNT) || lineBreakFlag;
  assign rxPush = fifoStream.valid && fifoStream.ready && !lineBreakFlag;
  assign rxPop  = rxReadStrobe && (rxCount != 7'h00);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rxWrPtr    <= 6'h00;
      rxRdPtr    <= 6'h00;
      rxCount    <= 7'h00;
      rxReadData <= 8'h00;
    end else begin
      if (rxPush) begin
        rxMem[rxWrPtr] <= fifoStream.data;
        rxWrPtr        <= rxWrPtr + 6'h01;
      end
      if (rxPop) begin
        rxReadData <= rxMem[rxRdPtr];
        rxRdPtr    <= rxRdPtr + 6'h01;
      end
      rxCount <= rxCount + {6'h00, rxPush} - {6'h00, rxPop};
    end
  end

  assign fifoCount = {txCount, 1'b0, rxCount};

  // base clock at eight ticks per bit, realigned on the start edge
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      divCnt   <= 8'h00;
      baseTick <= 1'b0;
    end else if (rxState == RX_IDLE) begin
      divCnt   <= 8'h00;
      baseTick <= 1'b0;
    end else if (divCnt == baseDivisor) begin
      divCnt   <= 8'h00;
      baseTick <= 1'b1;
    end else begin
      divCnt   <= divCnt + 8'h01;
      baseTick <= 1'b0;
    end
  end

  assign sampleStrobe = baseTick && (tickCnt == SAMPLE_TICK);

  // receiver; reception carries on through faults and breaks
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rxState    <= RX_IDLE;
      prevPin    <= 1'b1;
      tickCnt    <= 3'h0;
      bitCnt     <= 4'h0;
      shiftData  <= 8'h00;
      parityAcc  <= 1'b0;
      wordDone   <= 1'b0;
      wordGood   <= 1'b0;
      frameFault <= 1'b0;
      parFault   <= 1'b0;
      breakSeen  <= 1'b0;
    end else begin
      prevPin    <= serialInputPin;
      wordDone   <= 1'b0;
      frameFault <= 1'b0;
      parFault   <= 1'b0;
      breakSeen  <= 1'b0;
      if (baseTick) begin
        tickCnt <= tickCnt + 3'h1;
      end
      case (rxState)
        RX_IDLE: begin
          tickCnt <= 3'h0;
          if (prevPin && !serialInputPin) begin
            rxState <= RX_START;
          end
        end
        RX_START: begin
          if (sampleStrobe) begin
            // a glitch shorter than half a bit is not a start
            rxState   <= serialInputPin ? RX_IDLE : RX_DATA;
            bitCnt    <= 4'h0;
            parityAcc <= parityOdd;
          end
        end
        RX_DATA: begin
          if (sampleStrobe) begin
            shiftData <= {serialInputPin, shiftData[7:1]};
            parityAcc <= parityAcc ^ serialInputPin;
            bitCnt    <= bitCnt + 4'h1;
            if (bitCnt == DATA_BITS - 4'h1) begin
              rxState <= parityEnable ? RX_PARITY : RX_STOP;
            end
          end
        end
        RX_PARITY: begin
          if (sampleStrobe) begin
            parFault <= parityAcc ^ serialInputPin;
            rxState  <= RX_STOP;
          end
        end
        RX_STOP: begin
          if (sampleStrobe) begin
            wordDone   <= 1'b1;
            wordGood   <= serialInputPin;
            frameFault <= !serialInputPin;
            breakSeen  <= !serialInputPin && (shiftData == 8'h00);
            rxState    <= RX_IDLE;
          end
        end
        default: rxState <= RX_IDLE;
      endcase
    end
  end

  // hand good words to the buffer; a word still unaccepted is overrun
  assign rxStream.valid = rxValid;
  assign rxStream.data  = rxWord;
  assign overrun = wordDone && wordGood && rxValid && !rxStream.ready;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rxValid <= 1'b0;
      rxWord  <= 8'h00;
    end else if (wordDone && wordGood && !(rxValid && !rxStream.ready)) begin
      rxValid <= 1'b1;
      rxWord  <= shiftData;
    end else if (rxStream.ready) begin
      rxValid <= 1'b0;
    end
  end

  // fault detail flags, cleared together with the fault flag
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      framingFaultFlag <= 1'b0;
      parityFaultFlag  <= 1'b0;
    end else begin
      framingFaultFlag <= frameFault || (framingFaultFlag && !flagClear[SRC_FAULT]);
      parityFaultFlag  <= parFault || (parityFaultFlag && !flagClear[SRC_FAULT]);
    end
  end

  // level-set flags re-arm at once if cleared while the fill still qualifies
  assign flagSet[SRC_TXLOW]  = (txCount <= txTrig);
  assign flagSet[SRC_TXSTOP] = txStopEvent;
  assign flagSet[SRC_RXFULL] = (rxCount >= rxTrig);
  assign flagSet[SRC_FAULT]  = frameFault || parFault || overrun;
  assign flagSet[SRC_BREAK]  = breakSeen;
  assign flagSet[SRC_IDLE]   = rxIdleEvent;

  assign stopAutoClear = stopDma && (statusRead || txCount == FIFO_FULL_CNT);

  // set wins over any clear in the same cycle
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      flags <= FLAGS_RESET;
    end else begin
      flags <= flagSet | (flags & ~flagClear);
      if (stopAutoClear && !txStopEvent) begin
        flags[SRC_TXSTOP] <= 1'b0;
      end
    end
  end

  // remembers that the stop flag launched a dma transfer
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      stopDma <= 1'b0;
    end else if (!flags[SRC_TXSTOP]) begin
      stopDma <= 1'b0;
    end else if (active[SRC_TXSTOP] && dmaTxSelect) begin
      stopDma <= 1'b1;
    end
  end

  assign enables = {rxIdleIrqEnable, lineBreakIrqEnable, rxFaultIrqEnable,
                    rxFullIrqEnable, txStopIrqEnable, txFifoIrqEnable};
  assign toDma   = {3'h0, dmaRxSelect, dmaTxSelect, dmaTxSelect};

  genvar s;
  generate
    for (s = 0; s < NUM_SRC; s++) begin : gSrc
      // clock-synchronous mode silences four of the sources
      assign active[s] = flags[s] && enables[s] && (!syncMode || SYNC_MODE_MASK[s]);
      assign irqOut[s] = active[s] && !toDma[s];
    end
  endgenerate

  assign {rxIdleReadyFlag, lineBreakFlag, rxFaultFlag,
          rxFifoFullFlag, txStopFlag, txFifoLowFlag} = flags;
  assign txLowRequest   = irqOut[SRC_TXLOW];
  assign txStopRequest  = irqOut[SRC_TXSTOP];
  assign rxFullRequest  = irqOut[SRC_RXFULL];
  assign rxFaultRequest = irqOut[SRC_FAULT];
  assign breakRequest   = irqOut[SRC_BREAK];
  assign rxIdleRequest  = irqOut[SRC_IDLE];
  assign txVectorIrq    = txLowRequest || txStopRequest;
  assign faultVectorIrq = rxFaultRequest || breakRequest;
  assign rxVectorIrq    = rxFullRequest || rxIdleRequest;
  assign dmaTxRequest   = (active[SRC_TXLOW] || active[SRC_TXSTOP]) && dmaTxSelect;
  assign dmaRxRequest   = active[SRC_RXFULL] && dmaRxSelect;

  sequence breakFrame;
    rxState == RX_STOP && sampleStrobe && !serialInputPin && shiftData == 8'h00;
  endsequence

  property breakFlags_p;
    @(posedge ref_clk) disable iff (rst)
      breakFrame |=> ##1 (lineBreakFlag && framingFaultFlag);
  endproperty

  sync_mode_gate_a : assert property (@(posedge ref_clk) disable iff (rst)
    syncMode |-> !(rxFaultRequest || breakRequest || rxIdleRequest || txStopRequest))
    else $error("async-only source active in sync mode");
  enable_gate_a : assert property (@(posedge ref_clk) disable iff (rst)
    $fell(rxFullIrqEnable) |-> !rxFullRequest) else $error("request outlived its enable");
  tx_low_set_a : assert property (@(posedge ref_clk) disable iff (rst)
    !rst && (txCount <= txTrig) |=> txFifoLowFlag) else $error("tx low flag not set");
  rx_full_set_a : assert property (@(posedge ref_clk) disable iff (rst)
    !rst && (rxCount >= rxTrig) |=> rxFifoFullFlag) else $error("rx full flag not set");
  stop_flag_set_a : assert property (@(posedge ref_clk) disable iff (rst)
    txStopEvent |=> txStopFlag) else $error("tx stop flag not set");
  stop_auto_clear_a : assert property (@(posedge ref_clk) disable iff (rst)
    (stopDma && statusRead && !txStopEvent) |=> !txStopFlag)
    else $error("dma stop flag not cleared by read");
  dma_exclusive_a : assert property (@(posedge ref_clk) disable iff (rst)
    !(dmaTxRequest && (txLowRequest || txStopRequest)) && !(dmaRxRequest && rxFullRequest))
    else $error("interrupt and dma from one source");
  dma_sources_a : assert property (@(posedge ref_clk) disable iff (rst)
    (dmaTxRequest |-> (txFifoLowFlag || txStopFlag)) and (dmaRxRequest |-> rxFifoFullFlag))
    else $error("dma request without its flag");
  break_flags_a : assert property (breakFlags_p)
    else $error("break not flagged");
  break_no_push_a : assert property (@(posedge ref_clk) disable iff (rst)
    lineBreakFlag |=> $stable(rxWrPtr)) else $error("word stored during break");
  count_field_a : assert property (@(posedge ref_clk) disable iff (rst)
    $rose(txPush && !txPop) |=> fifoCount[14:8] == $past(txCount) + 7'h01)
    else $error("tx count field wrong");
endmodule

// *** dv/irq_dma_partner.sv ***
// interrupt controller and dma controller model facing the request outputs
`timescale 1ns/100ps
module irq_dma_partner (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst,
  // requests from the port
  input  wire logic [2:0] vectorIrq,
  input  wire logic       dmaTxRequest,
  // bench control
  input  wire logic       dmaOn,
  input  wire logic [2:0] irqMask,
  // responses
  output logic      [2:0] irqPending,
  output logic            dmaWrite,
  output logic      [7:0] dmaData
);
  // software masks the vector of a source that dma serves
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst)
      irqPending <= 3'h0;
    else
      irqPending <= vectorIrq & ~irqMask;
  end

  // one byte per cycle while requested; dmaOn low models a stalled channel
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      dmaWrite <= 1'b0;
      dmaData  <= 8'h00;
    end else begin
      dmaWrite <= dmaOn & dmaTxRequest;
      dmaData  <= dmaData + 8'h01;
    end
  end
endmodule

// *** dv/fifo_serial_irq_tb.sv ***
// self-checking bench for the fifo serial port request logic
`timescale 1ns/100ps
module fifo_serial_irq_tb
  import serial_irq_pkg::*;
;
  logic        ref_clk, rst, syncMode, parityEnable, parityOdd, serialInputPin;
  logic [1:0]  txTriggerLevel, rxTriggerLevel;
  logic [7:0]  baseDivisor, tbData, txPopData, rxReadData, dmaData, wrData;
  logic        txFifoIrqEnable, rxFullIrqEnable, rxFaultIrqEnable, lineBreakIrqEnable;
  logic        rxIdleIrqEnable, txStopIrqEnable, dmaTxSelect, dmaRxSelect, statusRead;
  logic [5:0]  flagClear;
  logic        txStopEvent, rxIdleEvent, tbWrite, dmaWrite, wrStrobe, txPopStrobe;
  logic        rxReadStrobe, txFifoLowFlag, txStopFlag, rxFifoFullFlag, rxFaultFlag;
  logic        lineBreakFlag, rxIdleReadyFlag, framingFaultFlag, parityFaultFlag;
  logic        txLowRequest, txStopRequest, rxFullRequest, rxFaultRequest, breakRequest;
  logic        rxIdleRequest, txVectorIrq, faultVectorIrq, rxVectorIrq;
  logic        dmaTxRequest, dmaRxRequest, dmaOn;
  logic [14:0] fifoCount;
  logic [2:0]  irqMask, irqPending;
  int          error_cnt, n_checks;

  assign wrStrobe = tbWrite | dmaWrite;
  assign wrData   = dmaWrite ? dmaData : tbData;

  fifo_serial_irq dut (.ref_clk, .rst, .syncMode, .txTriggerLevel, .rxTriggerLevel,
    .baseDivisor, .parityEnable, .parityOdd, .txFifoIrqEnable, .rxFullIrqEnable,
    .rxFaultIrqEnable, .lineBreakIrqEnable, .rxIdleIrqEnable, .txStopIrqEnable,
    .dmaTxSelect, .dmaRxSelect, .flagClear, .statusRead, .txStopEvent, .rxIdleEvent,
    .serialInputPin, .txWriteStrobe(wrStrobe), .txWriteData(wrData), .txPopStrobe,
    .txPopData, .rxReadStrobe, .rxReadData, .fifoCount, .txFifoLowFlag, .txStopFlag,
    .rxFifoFullFlag, .rxFaultFlag, .lineBreakFlag, .rxIdleReadyFlag, .framingFaultFlag,
    .parityFaultFlag, .txLowRequest, .txStopRequest, .rxFullRequest, .rxFaultRequest,
    .breakRequest, .rxIdleRequest, .txVectorIrq, .faultVectorIrq, .rxVectorIrq,
    .dmaTxRequest, .dmaRxRequest);

  irq_dma_partner partner (.ref_clk, .rst,
    .vectorIrq({rxVectorIrq, faultVectorIrq, txVectorIrq}), .dmaTxRequest, .dmaOn,
    .irqMask, .irqPending, .dmaWrite, .dmaData);

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [14:0] got, input logic [14:0] exp, input string m);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  // k selects the one-cycle strobe: clear, stop, idle, status read, tx pop, rx read
  task automatic strobe(input int k, input logic [5:0] v);
    @(posedge ref_clk);
    case (k)
      0: flagClear <= v;
      1: txStopEvent <= 1'b1;
      2: rxIdleEvent <= 1'b1;
      3: statusRead <= 1'b1;
      4: txPopStrobe <= 1'b1;
      default: rxReadStrobe <= 1'b1;
    endcase
    @(posedge ref_clk);
    {flagClear, txStopEvent, rxIdleEvent, statusRead, txPopStrobe, rxReadStrobe} <= '0;
    #1;
  endtask

  task automatic push(input int n);
    repeat (n) begin
      @(posedge ref_clk);
      tbWrite <= 1'b1;
      tbData  <= tbData + 8'h01;
    end
    @(posedge ref_clk);
    tbWrite <= 1'b0;
    #1;
  endtask

  // base tick every cycle, so one bit lasts eight clocks
  task automatic sendb(input logic [7:0] d, input logic stopBit);
    @(posedge ref_clk);
    serialInputPin <= 1'b0;
    repeat (8) @(posedge ref_clk);
    for (int i = 0; i < 8; i++) begin
      serialInputPin <= d[i];
      repeat (8) @(posedge ref_clk);
    end
    serialInputPin <= stopBit;
    repeat (8) @(posedge ref_clk);
    serialInputPin <= 1'b1;
    cyc(16);
  endtask

  task automatic t_tx;
    cyc(2);
    chk(txFifoLowFlag, 15'h1, "low after reset");
    chk(txLowRequest, 15'h1, "low request");
    chk(txVectorIrq, 15'h1, "tx vector from low");
    chk(fifoCount, 15'h0, "counts after reset");
    push(9);
    chk(fifoCount, 15'h0900, "tx count nine");
    strobe(0, 6'h01);
    chk(txFifoLowFlag, 15'h0, "low cleared above trigger");
    strobe(4, 6'h00);
    chk(txPopData, 15'h0001, "first byte popped");
    cyc(1);
    chk(txFifoLowFlag, 15'h1, "low at trigger");
    strobe(0, 6'h01);
    chk(txFifoLowFlag, 15'h1, "low sets again");
    @(posedge ref_clk);
    txFifoIrqEnable <= 1'b0;
    #1;
    chk(txLowRequest, 15'h0, "low request disabled");
    @(posedge ref_clk);
    txFifoIrqEnable <= 1'b1;
    $display("test tx trigger done");
  endtask

  task automatic t_stop;
    strobe(1, 6'h00);
    chk(txStopRequest, 15'h1, "stop request");
    @(posedge ref_clk);
    syncMode <= 1'b1;
    #1;
    chk(txStopRequest, 15'h0, "stop gone in sync mode");
    chk(txLowRequest, 15'h1, "low kept in sync mode");
    @(posedge ref_clk);
    syncMode        <= 1'b0;
    txStopIrqEnable <= 1'b0;
    #1;
    chk(txStopRequest, 15'h0, "stop request disabled");
    @(posedge ref_clk);
    txStopIrqEnable <= 1'b1;
    strobe(0, 6'h02);
    chk(txStopRequest, 15'h0, "stop request cleared");
    strobe(2, 6'h00);
    chk(rxIdleRequest, 15'h1, "idle request");
    chk(rxIdleReadyFlag, 15'h1, "idle flag");
    cyc(1);
    chk(irqPending[2], 15'h1, "rx vector from idle");
    chk(dmaRxRequest, 15'h0, "idle never dma");
    strobe(0, 6'h20);
    $display("test stop and idle done");
  endtask

  task automatic t_rx;
    sendb(8'hA5, 1'b1);
    chk(fifoCount, 15'h0801, "rx count one");
    chk(rxFullRequest, 15'h1, "rx full request");
    strobe(0, 6'h04);
    chk(rxFifoFullFlag, 15'h1, "full sets again");
    @(posedge ref_clk);
    dmaRxSelect <= 1'b1;
    #1;
    chk(rxFullRequest, 15'h0, "no irq with dma");
    chk(dmaRxRequest, 15'h1, "rx dma request");
    @(posedge ref_clk);
    dmaRxSelect     <= 1'b0;
    rxFullIrqEnable <= 1'b0;
    #1;
    chk(rxFullRequest, 15'h0, "full request disabled");
    @(posedge ref_clk);
    rxFullIrqEnable <= 1'b1;
    strobe(5, 6'h00);
    chk(rxReadData, 15'h00A5, "received byte");
    strobe(0, 6'h04);
    chk(rxFifoFullFlag, 15'h0, "full cleared when empty");
    sendb(8'h00, 1'b0);
    chk(framingFaultFlag, 15'h1, "framing on break");
    chk(breakRequest, 15'h1, "break request");
    chk(rxFaultFlag, 15'h1, "fault flag on break");
    chk(dmaRxRequest, 15'h0, "break never dma");
    cyc(1);
    chk(irqPending[1], 15'h1, "fault vector from break");
    sendb(8'h5A, 1'b1);
    chk(fifoCount[6:0], 15'h0, "no store after break");
    strobe(0, 6'h18);
    // even parity: one data bit set with a zero parity bit is a fault
    @(posedge ref_clk);
    parityEnable <= 1'b1;
    sendb(8'h01, 1'b0);
    chk(parityFaultFlag, 15'h1, "parity fault");
    chk(rxFaultRequest, 15'h1, "fault request");
    @(posedge ref_clk);
    parityEnable <= 1'b0;
    $display("test receive done");
  endtask

  task automatic t_dma;
    @(posedge ref_clk);
    dmaTxSelect <= 1'b1;
    dmaOn       <= 1'b1;
    irqMask     <= 3'h1;
    #1;
    chk(txLowRequest, 15'h0, "no tx irq with dma");
    chk(dmaTxRequest, 15'h1, "tx dma request");
    for (int k = 0; k < 200 && fifoCount[14:8] !== FIFO_FULL_CNT; k++) cyc(1);
    chk(fifoCount[14:8], 15'h40, "dma filled tx fifo");
    chk(irqPending[0], 15'h0, "tx vector masked");
    @(posedge ref_clk);
    dmaOn <= 1'b0;
    strobe(0, 6'h01);
    chk(dmaTxRequest, 15'h0, "dma request cleared");
    strobe(1, 6'h00);
    cyc(3);
    chk(txStopFlag, 15'h0, "stop cleared by full fifo");
    strobe(4, 6'h00);
    strobe(1, 6'h00);
    cyc(3);
    chk(txStopFlag, 15'h1, "stop held until read");
    strobe(3, 6'h00);
    chk(txStopFlag, 15'h0, "stop cleared by read");
    $display("test dma done");
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    {rst, serialInputPin, txFifoIrqEnable, rxFullIrqEnable, rxFaultIrqEnable} = 5'h1F;
    {lineBreakIrqEnable, rxIdleIrqEnable, txStopIrqEnable} = 3'h7;
    {syncMode, parityEnable, parityOdd, dmaTxSelect, dmaRxSelect, dmaOn} = 6'h00;
    {txTriggerLevel, rxTriggerLevel, baseDivisor, tbData, irqMask} = '0;
    {flagClear, statusRead, txStopEvent, rxIdleEvent, tbWrite} = '0;
    {txPopStrobe, rxReadStrobe, error_cnt, n_checks} = '0;
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    t_tx();
    t_stop();
    t_rx();
    t_dma();
    conclude();
  end

  // whole run is a little over five hundred cycles
  initial begin
    repeat (6000) @(posedge ref_clk);
    error_cnt++;
    conclude();
  end
endmodule
